/* inc/stic_consts.svh */
// Offsets, field positions, reset values and timing counts of the block
`ifndef STIC_CONSTS_SVH
`define STIC_CONSTS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define STIC_ADDR_PORT6     16'hFFCC
`define STIC_ADDR_ENABLE    16'hFFCE
`define STIC_ADDR_EDGE_RATE 16'hFFEE
`define STIC_ADDR_CAP_MASK  16'hFFF0
`define STIC_ADDR_DRUM_DIV  16'hFFF1
`define STIC_ADDR_CAP_DIV   16'hFFF2
`define STIC_ADDR_FLAG_RST  16'hFFF3
`define STIC_ADDR_STATUS2   16'hFFFF
// ----------------------------------------
// Field positions
// ----------------------------------------
`define STIC_EN_DFG         0
`define STIC_EN_DPG         1
`define STIC_EN_CFG         2
`define STIC_ER_DPG_EDGE    1
`define STIC_ER_RATE_B      3
`define STIC_ER_RATE_A      4
`define STIC_ER_DFG_EDGE    5
`define STIC_ER_PG_SYNC     6
`define STIC_ER_PG_SEEN     7
`define STIC_FR_DPG_CLR     0
`define STIC_FR_MASK_CLR    1
`define STIC_P6_DFG         4
`define STIC_P6_DPG         5
`define STIC_P6_CFG         6
// ----------------------------------------
// Reset values
// ----------------------------------------
`define STIC_RST_ENABLE     6'h00
`define STIC_RST_CTRL       7'h00
`define STIC_RST_DRUM_DIV   3'h0
`define STIC_RST_CAP_DIV    5'h00
`define STIC_RST_MASK       4'h0
// ----------------------------------------
// Timing
// ----------------------------------------
`define STIC_CLK_PERIOD_NS  8
`define STIC_TAP8_PERIOD_NS 51200
`define STIC_TAP8_CYCLES    (`STIC_TAP8_PERIOD_NS / `STIC_CLK_PERIOD_NS)
`endif

/* inc/stic_pkg.sv */
// Types shared by the tach input conditioner modules
package stic_pkg;
    // Capstan sampling rate choices
    typedef enum logic [1:0] {
        STIC_RATE_ONE,
        STIC_RATE_DOUBLE,
        STIC_RATE_HALF
    } stic_rate_type;
    // One register byte
    typedef logic [7:0] stic_byte_type;
endpackage

/* inc/stic_div_if.sv */
// Link between the top module and a programmable divider
`timescale 1ns/1ns
interface stic_div_if;
    logic [4:0] ratio; // Field value k divides by k+1
    logic       tick;  // One-cycle input event
    logic       clear; // Restart the count
    logic       out;   // One-cycle divided event
    modport ctrl (output ratio, output tick, output clear, input out);
    modport div  (input ratio, input tick, input clear, output out);
endinterface

/* core/stic_div.sv */
// Programmable event divider, ratio k+1
`timescale 1ns/1ns
module stic_div
    import stic_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    stic_div_if.div  dif
);
    logic [4:0] cnt_q; // Events seen since last output

    // ----------------------------------------
    // Counter and output pulse
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q   <= 5'h00;
            dif.out <= 1'b0;
        end else if (dif.clear) begin
            // Restart wins over a counted event
            cnt_q   <= 5'h00;
            dif.out <= 1'b0;
        end else if (dif.tick) begin
            // Terminal event wraps and emits
            cnt_q   <= (cnt_q >= dif.ratio) ? 5'h00 : cnt_q + 5'h01;
            dif.out <= (cnt_q >= dif.ratio);
        end else begin
            dif.out <= 1'b0;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    div_terminal_a: assert property (@(posedge clock) disable iff (!rst_n)
        (dif.tick && !dif.clear && cnt_q == dif.ratio) |=> dif.out)
        else $error("divider missed its terminal event");
    div_early_a: assert property (@(posedge clock) disable iff (!rst_n)
        (dif.tick && cnt_q < dif.ratio) |=> !dif.out)
        else $error("divider emitted early");
endmodule // stic_div

/* core/stic_mask.sv */
// Capstan mask counter clocked by the tap enable
`timescale 1ns/1ns
module stic_mask
    import stic_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       tap_en,
    input  wire logic       event_in,
    input  wire logic [3:0] mask_n,
    output logic            pass_q,
    output logic            hit_q
);
    logic [3:0] cnt_q; // Tap periods left in the mask window

    // ----------------------------------------
    // Window counter
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 4'h0;
        end else if (event_in && cnt_q == 4'h0) begin
            cnt_q <= mask_n; // Zero gives no window
        end else if (tap_en && cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end
    end

    // ----------------------------------------
    // Pass or suppress each event
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pass_q <= 1'b0;
            hit_q  <= 1'b0;
        end else begin
            pass_q <= event_in && cnt_q == 4'h0;
            hit_q  <= event_in && cnt_q != 4'h0;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    mask_suppress_a: assert property (@(posedge clock) disable iff (!rst_n)
        (event_in && cnt_q != 4'h0) |=> (hit_q && !pass_q))
        else $error("event leaked through mask window");
    mask_load_a: assert property (@(posedge clock) disable iff (!rst_n)
        (event_in && cnt_q == 4'h0) |=> (cnt_q == $past(mask_n)))
        else $error("mask window not loaded");
    mask_cov: cover property (@(posedge clock) disable iff (!rst_n)
        event_in && cnt_q != 4'h0);
endmodule // stic_mask

/* core/stic_top.sv */
// Drum and capstan tach input conditioner with register port
// Operation
// - Separate edge select for drum FG, PG
// - Drum FG divided by field plus one
// - PG edge restarts drum divider when enabled
// - Drum FG and PG individually gated
// - Drum pins readable as port bits
// - PG seen flag, write one clears
// - Capstan FG level feeds timer two
// - Capstan input gated by enable bit
// - Capstan rate select half, one, double
// - Capstan path through five bit divider
// - Mask counter suppresses early capstan events
// - Capstan pin readable as port bit
// - Enable bit zero enables, resets zero
// - Capstan field value k divides k+1
// - Mask lasts n tap periods, zero none
// - Masked event sets violation, one clears
//
// Our own choice: the strobed register port.
`timescale 1ns/1ns
`include "stic_consts.svh"
module stic_top
    import stic_pkg::*;
#(
    parameter int unsigned TAP8_CYCLES = `STIC_TAP8_CYCLES
)
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        drum_fg_pin,
    input  wire logic        drum_pg_pin,
    input  wire logic        capstan_fg_pin,
    input  wire logic [15:0] addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output stic_byte_type    rdata_q,
    output logic             drum_fg_div_q,
    output logic             drum_pg_pulse_q,
    output logic             capstan_event_q,
    output logic             capstan_tmr_clk_q,
    output logic             mask_violation_q,
    output logic             drum_pg_seen_q
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [2:0]    sync1_q;      // First synchroniser stage
    logic [2:0]    sync2_q;      // Second synchroniser stage
    logic [2:0]    prev_q;       // Previous synchronised level
    logic [2:0]    rise;         // Rising edge per pin
    logic [2:0]    fall;         // Falling edge per pin
    logic [5:0]    enable_q;     // Input disable bits
    logic [6:0]    ctrl_q;       // Edge and rate control bits
    logic [2:0]    drum_div_q;   // Drum ratio field
    logic [4:0]    cap_div_q;    // Capstan ratio field
    logic [3:0]    mask_q;       // Mask time field
    logic          dfg_edge;     // Selected drum FG edge
    logic          dpg_edge;     // Selected drum PG edge
    logic          cfg_edge;     // Rate-selected capstan edge
    logic          dfg_tick_q;   // Drum FG event pulse
    logic          cfg_tick_q;   // Capstan event pulse
    logic          half_q;       // Every other edge for half rate
    logic [15:0]   tap_cnt_q;    // Tap prescaler count
    logic          tap_en_q;     // One pulse per tap period
    logic          wr_flag;      // Write to flag reset register
    logic          pg_clr;       // Drum PG flag clear pulse
    logic          mask_clr;     // Violation flag clear pulse
    logic          mask_hit;     // Event arrived during mask
    logic          cap_pass;     // Event passed the mask
    stic_rate_type rate;         // Decoded sampling rate
    stic_byte_type rd_mux;       // Read data before the register
    stic_div_if    drum_if ();   // Drum divider link
    stic_div_if    cap_if ();    // Capstan divider link

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Two flops per pin, third flop keeps history for edges
    for (genvar i = 0; i < 3; i++) begin : g_sync
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                sync1_q[i] <= 1'b0;
                sync2_q[i] <= 1'b0;
                prev_q[i]  <= 1'b0;
            end else begin
                sync1_q[i] <= (i == 0) ? drum_fg_pin :
                              (i == 1) ? drum_pg_pin : capstan_fg_pin;
                sync2_q[i] <= sync1_q[i];
                prev_q[i]  <= sync2_q[i];
            end
        end
        assign rise[i] = sync2_q[i] & ~prev_q[i];
        assign fall[i] = ~sync2_q[i] & prev_q[i];
    end

    // ----------------------------------------
    // Edge selection and gating
    // ----------------------------------------
    // Edge select bit zero picks rising, one picks falling
    assign dfg_edge = ~enable_q[`STIC_EN_DFG] &
        (ctrl_q[`STIC_ER_DFG_EDGE] ? fall[0] : rise[0]);
    assign dpg_edge = ~enable_q[`STIC_EN_DPG] &
        (ctrl_q[`STIC_ER_DPG_EDGE] ? fall[1] : rise[1]);

    // Rate select: bit A picks half, else bit B picks double
    always_comb begin
        if (ctrl_q[`STIC_ER_RATE_A]) begin
            rate = STIC_RATE_HALF;
        end else if (ctrl_q[`STIC_ER_RATE_B]) begin
            rate = STIC_RATE_DOUBLE;
        end else begin
            rate = STIC_RATE_ONE;
        end
    end

    // Capstan edge after the rate selector
    always_comb begin
        case (rate)
            STIC_RATE_DOUBLE: cfg_edge = rise[2] | fall[2];
            STIC_RATE_HALF:   cfg_edge = rise[2] & half_q;
            default:          cfg_edge = rise[2];
        endcase
        cfg_edge = cfg_edge & ~enable_q[`STIC_EN_CFG];
    end

    // Half rate phase toggles on every rising capstan edge
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            half_q <= 1'b0;
        end else if (rise[2]) begin
            half_q <= ~half_q;
        end
    end

    // ----------------------------------------
    // Event pulses
    // ----------------------------------------
    // Each edge becomes one registered pulse of one cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dfg_tick_q      <= 1'b0;
            drum_pg_pulse_q <= 1'b0;
            cfg_tick_q      <= 1'b0;
        end else begin
            dfg_tick_q      <= dfg_edge;
            drum_pg_pulse_q <= dpg_edge;
            cfg_tick_q      <= cfg_edge;
        end
    end

    // Timer two clock follows the synchronised pin level
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            capstan_tmr_clk_q <= 1'b0;
        end else begin
            capstan_tmr_clk_q <= sync2_q[2];
        end
    end

    // ----------------------------------------
    // Dividers
    // ----------------------------------------
    assign drum_if.ratio = {2'b00, drum_div_q};
    assign drum_if.tick  = dfg_tick_q;
    assign drum_if.clear = drum_pg_pulse_q & ctrl_q[`STIC_ER_PG_SYNC];
    assign drum_fg_div_q = drum_if.out;
    assign cap_if.ratio  = cap_div_q;
    assign cap_if.tick   = cfg_tick_q;
    assign cap_if.clear  = 1'b0;

    stic_div u_drum_div (
        .clock (clock),
        .rst_n (rst_n),
        .dif   (drum_if.div)
    );

    stic_div u_cap_div (
        .clock (clock),
        .rst_n (rst_n),
        .dif   (cap_if.div)
    );

    // ----------------------------------------
    // Tap prescaler and mask counter
    // ----------------------------------------
    // One enable pulse per tap period
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tap_cnt_q <= 16'h0000;
            tap_en_q  <= 1'b0;
        end else if (tap_cnt_q == 16'(TAP8_CYCLES - 1)) begin
            tap_cnt_q <= 16'h0000;
            tap_en_q  <= 1'b1;
        end else begin
            tap_cnt_q <= tap_cnt_q + 16'h0001;
            tap_en_q  <= 1'b0;
        end
    end

    stic_mask u_mask (
        .clock    (clock),
        .rst_n    (rst_n),
        .tap_en   (tap_en_q),
        .event_in (cap_if.out),
        .mask_n   (mask_q),
        .pass_q   (cap_pass),
        .hit_q    (mask_hit)
    );
    assign capstan_event_q = cap_pass;

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    // Configuration registers, all disables clear at reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            enable_q   <= `STIC_RST_ENABLE;
            ctrl_q     <= `STIC_RST_CTRL;
            drum_div_q <= `STIC_RST_DRUM_DIV;
            cap_div_q  <= `STIC_RST_CAP_DIV;
            mask_q     <= `STIC_RST_MASK;
        end else if (wr_en) begin
            if (addr == `STIC_ADDR_ENABLE) begin
                enable_q <= wdata[5:0];
            end else if (addr == `STIC_ADDR_EDGE_RATE) begin
                ctrl_q <= wdata[6:0];
            end else if (addr == `STIC_ADDR_DRUM_DIV) begin
                drum_div_q <= wdata[7:5];
            end else if (addr == `STIC_ADDR_CAP_DIV) begin
                cap_div_q <= wdata[4:0];
            end else if (addr == `STIC_ADDR_CAP_MASK) begin
                mask_q <= wdata[7:4];
            end
        end
    end

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    assign wr_flag  = wr_en && addr == `STIC_ADDR_FLAG_RST;
    assign pg_clr   = wr_flag && wdata[`STIC_FR_DPG_CLR];
    assign mask_clr = wr_flag && wdata[`STIC_FR_MASK_CLR];

    // A new event wins over a clear in the same cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            drum_pg_seen_q   <= 1'b0;
            mask_violation_q <= 1'b0;
        end else begin
            drum_pg_seen_q   <= drum_pg_pulse_q |
                                (drum_pg_seen_q & ~pg_clr);
            mask_violation_q <= mask_hit |
                                (mask_violation_q & ~mask_clr);
        end
    end

    // ----------------------------------------
    // Register reads
    // ----------------------------------------
    always_comb begin
        rd_mux = 8'h00;
        if (addr == `STIC_ADDR_PORT6) begin
            rd_mux[`STIC_P6_DFG] = sync2_q[0];
            rd_mux[`STIC_P6_DPG] = sync2_q[1];
            rd_mux[`STIC_P6_CFG] = sync2_q[2];
        end else if (addr == `STIC_ADDR_ENABLE) begin
            rd_mux = {2'b00, enable_q};
        end else if (addr == `STIC_ADDR_EDGE_RATE) begin
            rd_mux = {drum_pg_seen_q, ctrl_q};
        end else if (addr == `STIC_ADDR_DRUM_DIV) begin
            rd_mux = {drum_div_q, 5'h00};
        end else if (addr == `STIC_ADDR_CAP_DIV) begin
            rd_mux = {3'h0, cap_div_q};
        end else if (addr == `STIC_ADDR_CAP_MASK) begin
            rd_mux = {mask_q, 4'h0};
        end else if (addr == `STIC_ADDR_STATUS2) begin
            rd_mux = {7'h00, mask_violation_q};
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rd_en ? rd_mux : 8'h00;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    fg_edge_sel_a: assert property (
        (!enable_q[0] && ctrl_q[5] && fall[0]) |=> dfg_tick_q)
        else $error("falling drum FG edge not taken");
    pg_sync_a: assert property (
        (dpg_edge && ctrl_q[6]) |=> ##1 !drum_fg_div_q)
        else $error("drum divider not restarted by PG");
    drum_gate_a: assert property (
        enable_q[1] |=> !drum_pg_pulse_q)
        else $error("disabled drum PG produced a pulse");
    pin_read_a: assert property (
        (rd_en && addr == 16'hFFCC) |=> rdata_q[4] == $past(sync2_q[0]))
        else $error("drum FG port bit wrong");
    pg_seen_a: assert property (
        drum_pg_pulse_q |=> drum_pg_seen_q)
        else $error("PG seen flag not set");
    timer_feed_a: assert property (
        ##1 capstan_tmr_clk_q == $past(sync2_q[2]))
        else $error("timer two feed does not follow pin");
    cap_gate_a: assert property (
        enable_q[2] |=> !cfg_tick_q)
        else $error("disabled capstan input produced event");
    rate_double_a: assert property (
        (rate == STIC_RATE_DOUBLE && !enable_q[2] && fall[2]) |=> cfg_tick_q)
        else $error("double rate missed a falling edge");
    cap_read_a: assert property (
        (rd_en && addr == 16'hFFCC) |=> rdata_q[6] == $past(sync2_q[2]))
        else $error("capstan port bit wrong");
    violation_a: assert property (
        mask_hit |=> mask_violation_q)
        else $error("mask violation flag not set");
    pulse_width_a: assert property (
        dfg_tick_q |=> !dfg_tick_q)
        else $error("drum FG pulse wider than one cycle");
    seen_clear_a: assert property (
        (pg_clr && !drum_pg_pulse_q) |=> !drum_pg_seen_q)
        else $error("PG seen flag not cleared");
    flag_clear_a: assert property (
        (mask_clr && !mask_hit) |=> !mask_violation_q)
        else $error("mask violation flag not cleared");

    drum_div_cov:  cover property (drum_fg_div_q && drum_div_q == 3'h7);
    pg_clear_cov:  cover property (drum_pg_seen_q ##1 pg_clr ##1
                                   !drum_pg_seen_q);
    cap_event_cov: cover property (cap_pass && mask_q != 4'h0);
    half_rate_cov: cover property (rate == STIC_RATE_HALF && cfg_tick_q);
endmodule // stic_top

/* testbench/stic_amp_model.sv */
// Sense amplifier model driving the shaped drum and capstan tach levels
`timescale 1ns/1ns
module stic_amp_model (
    input  wire logic clock,
    output logic      drum_fg_pin,
    output logic      drum_pg_pin,
    output logic      capstan_fg_pin
);
    logic [2:0] lvl_q; // Levels: 0 drum FG, 1 drum PG, 2 capstan FG

    initial lvl_q = 3'h0;
    assign drum_fg_pin    = lvl_q[0];
    assign drum_pg_pin    = lvl_q[1];
    assign capstan_fg_pin = lvl_q[2];

    // Full pulses, each level held 4 clocks, above the 2 clock minimum
    task automatic pulse(input int idx, input int n);
        for (int i = 0; i < 2 * n; i++) begin
            @(posedge clock);
            lvl_q[idx] <= ~lvl_q[idx];
            repeat (3) @(posedge clock);
        end
    endtask

    // One level change, then time for the event to come out
    task automatic step(input int idx);
        @(posedge clock);
        lvl_q[idx] <= ~lvl_q[idx];
        repeat (7) @(posedge clock);
    endtask
endmodule // stic_amp_model

/* testbench/test_servo_tach_input_conditioner.sv */
// Self-checking bench for the tach input conditioner
`timescale 1ns/1ns
`include "stic_consts.svh"
module test_servo_tach_input_conditioner
    import stic_pkg::*;
;
    logic          clock;        // System clock
    logic          rst_n;        // Reset, active low
    logic [15:0]   addr;         // Register address
    stic_byte_type wdata;        // Write data
    logic          wr_en;        // Write strobe
    logic          rd_en;        // Read strobe
    stic_byte_type rdata_q;      // Read data
    logic          fg_pin;       // Drum FG level
    logic          pg_pin;       // Drum PG level
    logic          cf_pin;       // Capstan FG level
    logic [2:0]    ev;           // Pulses: FG divided, PG, capstan
    logic          tmr_clk;      // Timer feed
    logic          mask_flag;    // Violation flag
    logic          seen_flag;    // PG seen flag
    int            cnt [3];      // Pulse counts per output
    int            fails;        // Mismatches
    int            total_checks; // Comparisons

    stic_amp_model amp_u (.clock(clock), .drum_fg_pin(fg_pin),
        .drum_pg_pin(pg_pin), .capstan_fg_pin(cf_pin));
    stic_top #(.TAP8_CYCLES(8)) dut_u (.clock(clock), .rst_n(rst_n),
        .drum_fg_pin(fg_pin), .drum_pg_pin(pg_pin),
        .capstan_fg_pin(cf_pin), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q),
        .drum_fg_div_q(ev[0]), .drum_pg_pulse_q(ev[1]),
        .capstan_event_q(ev[2]), .capstan_tmr_clk_q(tmr_clk),
        .mask_violation_q(mask_flag), .drum_pg_seen_q(seen_flag));

    // Count every one-cycle event pulse
    always @(posedge clock)
        for (int i = 0; i < 3; i++)
            if (ev[i] === 1'b1) cnt[i] <= cnt[i] + 1;

    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic chk(input string nm, input stic_byte_type e,
                       input stic_byte_type g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [15:0] a, input stic_byte_type d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rchk(input string nm, input logic [15:0] a,
                        input stic_byte_type e);
        @(posedge clock);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1 chk(nm, e, rdata_q);
    endtask
    task automatic dchk(input int i, input int b, input int e);
        repeat (6) @(posedge clock);
        chk("event count", 8'(e), 8'(cnt[i] - b));
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic reset_values();
        rchk("enable", `STIC_ADDR_ENABLE, 8'h00);
        rchk("edge rate", `STIC_ADDR_EDGE_RATE, 8'h00);
        rchk("drum div", `STIC_ADDR_DRUM_DIV, 8'h00);
        rchk("cap div", `STIC_ADDR_CAP_DIV, 8'h00);
        rchk("status2", `STIC_ADDR_STATUS2, 8'h00);
        wr(16'hFFF4, 8'hFF);
        rchk("unmapped", 16'hFFF4, 8'h00);
    endtask
    // Each drum selector alone picks its edge; PG seen sticks till cleared
    task automatic edge_select();
        int b;
        for (int i = 0; i < 2; i++)
            for (int f = 0; f < 2; f++) begin
                wr(`STIC_ADDR_EDGE_RATE, f ? (i ? 8'h02 : 8'h20) : 8'h00);
                b = cnt[i];
                amp_u.step(i);
                chk("rise", 8'(1 - f), 8'(cnt[i] - b));
                amp_u.step(i);
                chk("fall", 8'h01, 8'(cnt[i] - b));
            end
        rchk("seen bit", `STIC_ADDR_EDGE_RATE, 8'h82);
        chk("seen out", 8'h01, {7'h0, seen_flag});
        wr(`STIC_ADDR_FLAG_RST, 8'h01);
        rchk("seen clr", `STIC_ADDR_EDGE_RATE, 8'h02);
        wr(`STIC_ADDR_EDGE_RATE, 8'h00);
    endtask
    // Disabled inputs stay silent, port bits and timer feed still follow
    task automatic enables();
        int b;
        wr(`STIC_ADDR_ENABLE, 8'h07);
        rchk("enable", `STIC_ADDR_ENABLE, 8'h07);
        for (int i = 0; i < 3; i++) begin
            b = cnt[i];
            amp_u.pulse(i, 2);
            dchk(i, b, 0);
        end
        chk("seen off", 8'h00, {7'h0, seen_flag});
        for (int i = 0; i < 3; i++) amp_u.step(i);
        rchk("port high", `STIC_ADDR_PORT6, 8'h70);
        chk("timer feed", 8'h01, {7'h0, tmr_clk});
        wr(`STIC_ADDR_ENABLE, 8'h00);
        for (int i = 0; i < 3; i++) amp_u.step(i);
        rchk("port low", `STIC_ADDR_PORT6, 8'h00);
        chk("timer low", 8'h00, {7'h0, tmr_clk});
    endtask
    task automatic drum_divider();
        int b;
        for (int k = 0; k < 8; k++) begin
            wr(`STIC_ADDR_DRUM_DIV, 8'(k << 5));
            b = cnt[0];
            amp_u.pulse(0, 2 * (k + 1));
            dchk(0, b, 2);
        end
        rchk("drum div", `STIC_ADDR_DRUM_DIV, 8'hE0);
    endtask
    // PG edge after two FG events restarts the divide by four
    task automatic pg_sync();
        int b;
        wr(`STIC_ADDR_DRUM_DIV, 8'h60);
        wr(`STIC_ADDR_EDGE_RATE, 8'h40);
        amp_u.pulse(0, 2);
        amp_u.pulse(1, 1);
        b = cnt[0];
        amp_u.pulse(0, 3);
        dchk(0, b, 0);
        amp_u.pulse(0, 1);
        dchk(0, b, 1);
        wr(`STIC_ADDR_EDGE_RATE, 8'h00);
        wr(`STIC_ADDR_DRUM_DIV, 8'h00);
    endtask
    // Rate one, half, double, then the capstan divider at field values 1 and 31
    task automatic capstan_path();
        int b;
        stic_byte_type er [5] = '{8'h00, 8'h10, 8'h08, 8'h00, 8'h00};
        stic_byte_type dv [5] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h1F};
        int            np [5] = '{4, 4, 4, 4, 32};
        int            ex [5] = '{4, 2, 8, 2, 1};
        for (int j = 0; j < 5; j++) begin
            wr(`STIC_ADDR_EDGE_RATE, er[j]);
            wr(`STIC_ADDR_CAP_DIV, dv[j]);
            b = cnt[2];
            amp_u.pulse(2, np[j]);
            dchk(2, b, ex[j]);
        end
        rchk("cap div", `STIC_ADDR_CAP_DIV, 8'h1F);
        wr(`STIC_ADDR_CAP_DIV, 8'h00);
    endtask
    // Four tap periods of mask: second edge dropped and flagged
    task automatic mask_window();
        int b;
        wr(`STIC_ADDR_CAP_MASK, 8'h40);
        rchk("mask reg", `STIC_ADDR_CAP_MASK, 8'h40);
        b = cnt[2];
        amp_u.pulse(2, 2);
        dchk(2, b, 1);
        rchk("violation", `STIC_ADDR_STATUS2, 8'h01);
        chk("flag out", 8'h01, {7'h0, mask_flag});
        wr(`STIC_ADDR_FLAG_RST, 8'h02);
        rchk("flag clr", `STIC_ADDR_STATUS2, 8'h00);
        repeat (40) @(posedge clock);
        b = cnt[2];
        amp_u.pulse(2, 1);
        dchk(2, b, 1);
        rchk("no flag", `STIC_ADDR_STATUS2, 8'h00);
    endtask

    // Clock of 8 ns
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // Main sequence
    initial begin
        rst_n        = 1'b0;
        addr         = 16'h0000;
        wdata        = 8'h00;
        wr_en        = 1'b0;
        rd_en        = 1'b0;
        fails        = 0;
        total_checks = 0;
        cnt          = '{0, 0, 0};
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        reset_values();
        edge_select();
        enables();
        drum_divider();
        pg_sync();
        capstan_path();
        mask_window();
        end_of_test();
    end
    // Hang guard
    initial begin
        repeat (100000) @(posedge clock);
        fails++;
        end_of_test();
    end
endmodule // test_servo_tach_input_conditioner
